//--- shared/lcc_cfg.svh
// Constants of the logic cell cluster: sizes, config word layout, offsets.
// Included by the package, the cluster module and the testbench; definitions only.
`ifndef LCC_CFG_SVH
`define LCC_CFG_SVH

`define LCC_NCELL 10
`define LCC_GROUP 5

// Register map (byte addresses, one word each)
`define LCC_ADDR_W 8
`define LCC_OFS_CFG0 8'h00
`define LCC_OFS_QREG 8'h40
`define LCC_OFS_COMB 8'h44

// Cell config word fields
`define LCC_F_MASK_LO 0
`define LCC_F_ARITH 16
`define LCC_F_CSEL 17
`define LCC_F_START 18
`define LCC_F_LCHAIN 19
`define LCC_F_RCHAIN 20
`define LCC_F_PACK 21
`define LCC_F_OREG 22
`define LCC_F_COUNT 23
`define LCC_CFG_RST 32'h0000_0000

`endif

//--- shared/lcc_pkg.sv
// Types of the logic cell cluster.
// Assumes lcc_cfg.svh on the include path.
`include "lcc_cfg.svh"

package lcc_pkg;

    typedef enum logic {
        LCC_MODE_NORMAL,
        LCC_MODE_ARITH
    } lcc_mode_t;

    typedef struct packed {
        logic [`LCC_NCELL-1:0][31:0] cfg;
        logic [`LCC_NCELL-1:0] q;
        logic [31:0] rdata;
    } lcc_state_t;

endpackage : lcc_pkg

//--- verilog/lcc_cluster.sv
// Ten-cell logic cluster: lookup tables, carry-select chain, cell registers.
// Assumes same-clock drivers on every input and a config port master
// that never issues read and write together.
//
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "lcc_cfg.svh"

module lcc_cluster
    import lcc_pkg::*;
#(
    parameter int NCELL = `LCC_NCELL
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Config port
    input wire logic [`LCC_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Cell data inputs, four per cell
    input wire logic [`LCC_NCELL-1:0][3:0] cell_data,
    // Cluster-wide controls
    input wire logic cell_ena,
    input wire logic cell_aclr,
    input wire logic cell_aload,
    input wire logic cell_sclr,
    input wire logic cell_sload,
    input wire logic addnsub,
    // Chains from and to neighbouring clusters
    input wire logic cluster_carry_in,
    input wire logic reg_chain_in,
    output logic cluster_carry_out,
    output logic reg_chain_out,
    // Cell outputs
    output logic [`LCC_NCELL-1:0] cell_comb,
    output logic [`LCC_NCELL-1:0] cell_reg,
    output logic [`LCC_NCELL-1:0] cell_out
);

    generate
        if (NCELL != `LCC_NCELL) begin : g_bad_ncell
            $error("lcc_cluster: NCELL must match the packed state width");
        end
    endgenerate

    // ==============================================================
    // State and combinational datapath
    // ==============================================================
    lcc_state_t state_reg;
    lcc_state_t state_next;
    logic [NCELL-1:0] comb;
    logic [NCELL-1:0] qout;
    logic carry_final;

    always_comb begin : p_next
        logic c0;
        logic c1;
        logic grp_sel;
        logic grp_carry;
        logic selc;
        logic prev_comb;
        logic a;
        logic b;
        logic n0;
        logic n1;
        logic cnt;
        logic load_ok;
        logic dreg;
        logic rchain;
        logic [3:0] d;
        logic [3:0] idx;
        logic [31:0] cw;
        lcc_mode_t mode;
        c0 = 1'b0;
        c1 = 1'b1;
        grp_sel = cluster_carry_in;
        grp_carry = 1'b0;
        selc = 1'b0;
        prev_comb = 1'b0;
        a = 1'b0;
        b = 1'b0;
        n0 = 1'b0;
        n1 = 1'b0;
        cnt = 1'b0;
        load_ok = 1'b0;
        dreg = 1'b0;
        rchain = reg_chain_in;
        d = 4'h0;
        idx = 4'h0;
        cw = 32'h0000_0000;
        mode = LCC_MODE_NORMAL;
        state_next = state_reg;
        comb = '0;
        qout = '0;
        for (int i = 0; i < NCELL; i++) begin
            cw = state_reg.cfg[i];
            d = cell_data[i];
            mode = cw[`LCC_F_ARITH] ? LCC_MODE_ARITH : LCC_MODE_NORMAL;
            cnt = (mode == LCC_MODE_ARITH) && cw[`LCC_F_COUNT];
            // second group selected by fifth cell's carry
            if (i == `LCC_GROUP) begin
                grp_sel = grp_carry;
                c0 = 1'b0;
                c1 = 1'b1;
            end
            // counter feeds back own register, down adds all ones
            a = cnt ? state_reg.q[i] : d[0];
            b = cnt ? ~d[3] : d[1];
            if (mode == LCC_MODE_ARITH && !cnt) begin
                b = b ^ addnsub;
            end
            // chain may begin at any cell
            if (cw[`LCC_F_START]) begin
                // add/subtract seeds only the first carry
                c0 = cnt ? d[3] : addnsub;
                c1 = c0;
            end
            selc = grp_sel ? c1 : c0;
            // carry or fourth input, chained first input
            idx = {cw[`LCC_F_CSEL] ? selc : d[3], d[2], d[1],
                   (cw[`LCC_F_LCHAIN] && i != 0) ? prev_comb : d[0]};
            // precomputed sums for carry zero and one
            if (mode == LCC_MODE_ARITH) begin
                comb[i] = selc ? ~(a ^ b) : (a ^ b);
                // each chain carry picks its own carry-out
                n0 = c0 ? (a | b) : (a & b);
                n1 = c1 ? (a | b) : (a & b);
                c0 = n0;
                c1 = n1;
            end else begin
                // normal cells pass the chain to a cell table
                comb[i] = cw[`LCC_F_MASK_LO + idx];
            end
            if (i == `LCC_GROUP - 1) begin
                grp_carry = grp_sel ? c1 : c0;
            end
            prev_comb = comb[i];

            // packed register takes fourth input, table stays free
            if (cw[`LCC_F_RCHAIN]) begin
                dreg = rchain;
            end else if (mode == LCC_MODE_NORMAL && cw[`LCC_F_PACK]) begin
                dreg = d[3];
            end else begin
                dreg = comb[i];
            end
            load_ok = cell_ena && (!cnt || d[2]);
            // clear, then load, then enabled data
            if (cell_aclr) begin
                state_next.q[i] = 1'b0;
                qout[i] = 1'b0;
            end else if (cell_aload) begin
                state_next.q[i] = d[3];
                qout[i] = d[3];
            end else begin
                qout[i] = state_reg.q[i];
                // synchronous controls hit every enabled cell together; a counter cell also needs d[2]
                if (load_ok) begin
                    if (cell_sclr) begin
                        state_next.q[i] = 1'b0;
                    end else if (cell_sload) begin
                        state_next.q[i] = d[3];
                    end else begin
                        state_next.q[i] = dreg;
                    end
                end
            end
            rchain = state_reg.q[i];
        end
        // carry to next cluster up the column
        carry_final = grp_sel ? c1 : c0;

        // Config writes, reads answered from flops next cycle
        if (reg_wr && reg_addr[1:0] == 2'b00 && reg_addr[`LCC_ADDR_W-1:2] < NCELL[`LCC_ADDR_W-3:0]) begin
            state_next.cfg[reg_addr[`LCC_ADDR_W-1:2]] = reg_wdata;
        end
        state_next.rdata = 32'h0000_0000;
        if (reg_rd) begin
            if (reg_addr == `LCC_OFS_QREG) begin
                state_next.rdata[NCELL-1:0] = qout;
            end else if (reg_addr == `LCC_OFS_COMB) begin
                state_next.rdata[NCELL:0] = {carry_final, comb};
            end else if (reg_addr[1:0] == 2'b00 &&
                         reg_addr[`LCC_ADDR_W-1:2] < NCELL[`LCC_ADDR_W-3:0]) begin
                state_next.rdata = state_reg.cfg[reg_addr[`LCC_ADDR_W-1:2]];
            end
        end
    end : p_next

    // Async controls act through the output override, so flops only ever
    // take constants on reset.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_reg.cfg <= {NCELL{`LCC_CFG_RST}};
            state_reg.q <= '0;
            state_reg.rdata <= 32'h0000_0000;
        end else begin
            state_reg <= state_next;
        end
    end

    // ==============================================================
    // Outputs
    // ==============================================================
    always_comb begin
        for (int i = 0; i < NCELL; i++) begin
            // bypass for adders, register for accumulators
            cell_out[i] = state_reg.cfg[i][`LCC_F_OREG] ? qout[i] : comb[i];
        end
    end

    // both versions of the table output
    assign cell_comb = comb;
    assign cell_reg = qout;
    assign reg_chain_out = qout[NCELL-1];
    assign cluster_carry_out = carry_final;
    assign reg_rdata = state_reg.rdata;

    // ==============================================================
    // Checks
    // ==============================================================
    logic [NCELL-1:0] chk_a;
    logic [NCELL-1:0] chk_b;
    logic chk_plain;
    logic [NCELL:0] chk_sum;
    logic [NCELL-1:0] chk_d3;

    always_comb begin
        chk_plain = 1'b1;
        for (int i = 0; i < NCELL; i++) begin
            chk_a[i] = cell_data[i][0];
            chk_b[i] = cell_data[i][1] ^ addnsub;
            chk_d3[i] = cell_data[i][3];
            if (!state_reg.cfg[i][`LCC_F_ARITH] || state_reg.cfg[i][`LCC_F_COUNT] ||
                state_reg.cfg[i][`LCC_F_START] != (i == 0)) begin
                chk_plain = 1'b0;
            end
        end
        chk_sum = {1'b0, chk_a} + {1'b0, chk_b} + {{NCELL{1'b0}}, addnsub};
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_read_cfg0;
        reg_rd && reg_addr == `LCC_OFS_CFG0;
    endsequence

    sequence s_sync_clear;
        cell_sclr && cell_ena && !cell_aclr && !cell_aload && !chk_plain;
    endsequence

    chk_adder_sum: assert property (chk_plain |-> {cluster_carry_out, cell_comb} == chk_sum)
        else $error("carry-select sum or carry out wrong");

    chk_read_latency: assert property (s_read_cfg0 |=> reg_rdata == $past(state_reg.cfg[0])
        ##1 (reg_rdata == 0 || $past(reg_rd)))
        else $error("config read data not in the following cycle only");

    chk_sync_clear: assert property (s_sync_clear and !state_reg.cfg[0][`LCC_F_COUNT] |=> cell_reg[0] == 1'b0 || cell_aload)
        else $error("synchronous clear missed cell 0");

    chk_aload_value: assert property (cell_aload && !cell_aclr |-> cell_reg == chk_d3)
        else $error("asynchronous load not taken from fourth input");

    chk_aclr_zero: assert property (cell_aclr |-> cell_reg == '0 ##1 (cell_aclr || cell_aload || state_reg.q == '0 || cell_ena))
        else $error("asynchronous clear left a register set");

    chk_enable_hold: assert property (!cell_ena && !cell_aclr && !cell_aload ##1 !cell_aclr && !cell_aload |-> $stable(cell_reg))
        else $error("register moved without clock enable");

    chk_normal_table: assert property (!state_reg.cfg[0][`LCC_F_ARITH] && !state_reg.cfg[0][`LCC_F_CSEL]
        |-> cell_comb[0] == state_reg.cfg[0][cell_data[0]])
        else $error("normal mode table output wrong");

    chk_out_select: assert property (cell_out[1] == (state_reg.cfg[1][`LCC_F_OREG] ? cell_reg[1] : cell_comb[1]))
        else $error("cell output select wrong");

endmodule : lcc_cluster

//--- dv/lcc_nbr_model.sv
// Neighbour cluster model: carry and register chain from the cluster below.
// Assumes the cluster's clock and reset.
`timescale 1ns/1ps
module lcc_nbr_model (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Chains into the cluster
    output logic carry_out,
    output logic chain_out
);
    logic [7:0] lfsr_reg;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            lfsr_reg <= 8'h5a;
        end else begin
            lfsr_reg <= {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
        end
    end
    // New pseudo-random bit every cycle, so a design that uses it wrongly shows it
    assign carry_out = lfsr_reg[0];
    assign chain_out = lfsr_reg[7];
endmodule : lcc_nbr_model

//--- dv/lcc_cluster_tb_top.sv
// Testbench of the logic cell cluster; checks go through config port reads and direct output samples.
// Assumes lcc_cfg.svh on the include path.
`timescale 1ns/1ps
`include "lcc_cfg.svh"
module lcc_cluster_tb_top;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [9:0][3:0] cell_data = '0;
    logic cell_ena = 1'b0;
    logic cell_aclr = 1'b0;
    logic cell_aload = 1'b0;
    logic cell_sclr = 1'b0;
    logic cell_sload = 1'b0;
    logic addnsub = 1'b0;
    logic cc_in, rc_in, cc_out, rc_out;
    logic [9:0] comb, creg, cout;
    int fails = 0;
    int comparisons = 0;
    logic [63:0] exp_q[$];
    logic [63:0] m;
    logic rd_seen = 1'b0;
    logic [39:0] dv;
    logic [15:0] mask [10];
    logic [9:0] a, b, e;
    logic [10:0] s;

    always #5 clk = ~clk;

    lcc_cluster dut_u (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cell_data(cell_data),
        .cell_ena(cell_ena), .cell_aclr(cell_aclr), .cell_aload(cell_aload), .cell_sclr(cell_sclr),
        .cell_sload(cell_sload), .addnsub(addnsub), .cluster_carry_in(cc_in), .reg_chain_in(rc_in),
        .cluster_carry_out(cc_out), .reg_chain_out(rc_out), .cell_comb(comb), .cell_reg(creg),
        .cell_out(cout));
    lcc_nbr_model nbr_u (.clk(clk), .reset(reset), .carry_out(cc_in), .chain_out(rc_in));

    // ========================================
    // Checking
    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Read data stands only in the cycle after the strobe
    always @(posedge clk) begin
        if (rd_seen) begin
            m = exp_q.pop_front();
            check(reg_rdata & m[63:32], m[31:0]);
        end
        rd_seen <= reg_rd;
    end

    function automatic logic [9:0] d3of(input logic [39:0] v);
        for (int i = 0; i < 10; i++) begin
            d3of[i] = v[4*i+3];
        end
    endfunction : d3of

    // ========================================
    // Config port master
    task wr(input logic [7:0] ad, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= ad;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] ad, input logic [31:0] exp, input logic [31:0] msk);
        @(posedge clk);
        reg_addr <= ad;
        reg_rd <= 1'b1;
        exp_q.push_back({msk, exp});
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask : rd

    task wr_all(input logic [31:0] d);
        for (int i = 0; i < 10; i++) begin
            wr(8'(4*i), d);
        end
    endtask : wr_all

    task set_data(input logic [39:0] v);
        @(posedge clk);
        cell_data <= v;
    endtask : set_data

    task summarize;
        $display("counts: comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize

    // Whole run is under 300 cycles; this is over a hundred times that
    initial begin
        #300000;
        fails++;
        summarize();
    end

    // ========================================
    // Tests
    initial begin
        void'($urandom(32'h94c5));
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        for (int i = 0; i < 10; i++) begin
            rd(8'(4*i), 32'h0, 32'hffffffff);
        end
        rd(8'h80, 32'h0, 32'hffffffff);
        rd(`LCC_OFS_QREG, 32'h0, 32'hffffffff);
        $display("test reset done");
        // Any four-input function; add/subtract select must not matter
        repeat (4) begin
            for (int i = 0; i < 10; i++) begin
                mask[i] = 16'($urandom());
                wr(8'(4*i), {16'h0, mask[i]});
            end
            dv = {8'($urandom()), $urandom()};
            addnsub <= 1'($urandom());
            set_data(dv);
            for (int i = 0; i < 10; i++) begin
                e[i] = mask[i][dv[4*i +: 4]];
            end
            rd(`LCC_OFS_COMB, {22'h0, e}, 32'h3ff);
        end
        // Cell 1 inverts cell 0's table output over the lookup chain
        wr(8'h00, 32'h0000_aaaa);
        wr(8'h04, 32'h0008_5555);
        rd(`LCC_OFS_COMB, {30'h0, ~dv[0], dv[0]}, 32'h3);
        $display("test normal done");
        wr_all(32'h0001_0000);
        wr(8'h00, 32'h0005_0000);
        for (int k = 0; k < 12; k++) begin
            a = (k == 0) ? 10'h3ff : 10'($urandom());
            b = (k == 1) ? 10'h3ff : 10'($urandom());
            for (int i = 0; i < 10; i++) begin
                dv[4*i +: 4] = {2'($urandom()), b[i], a[i]};
            end
            addnsub <= k[0];
            set_data(dv);
            s = k[0] ? ({1'b0, a} + {1'b0, ~b} + 11'h1) : ({1'b0, a} + {1'b0, b});
            @(negedge clk);
            check({21'h0, cc_out, comb}, {21'h0, s});
            rd(`LCC_OFS_COMB, {21'h0, s}, 32'h7ff);
        end
        $display("test arith done");
        // Packed register takes d3 while the table is unrelated
        wr_all(32'h0060_0000);
        cell_ena <= 1'b1;
        dv = {8'($urandom()), $urandom()};
        set_data(dv);
        rd(`LCC_OFS_QREG, {22'h0, d3of(dv)}, 32'h3ff);
        @(negedge clk);
        check({22'h0, cout}, {22'h0, d3of(dv)});
        check({22'h0, creg}, {22'h0, d3of(dv)});
        check({31'h0, rc_out}, {31'h0, dv[39]});
        @(posedge clk);
        cell_sclr <= 1'b1;
        rd(`LCC_OFS_QREG, 32'h0, 32'h3ff);
        cell_sclr <= 1'b0;
        cell_ena <= 1'b0;
        dv = ~dv;
        set_data(dv);
        rd(`LCC_OFS_QREG, 32'h0, 32'h3ff);
        cell_aload <= 1'b1;
        rd(`LCC_OFS_QREG, {22'h0, d3of(dv)}, 32'h3ff);
        cell_aclr <= 1'b1;
        rd(`LCC_OFS_QREG, 32'h0, 32'h3ff);
        cell_aclr <= 1'b0;
        cell_aload <= 1'b0;
        wr_all(32'h0);
        cell_ena <= 1'b1;
        cell_sload <= 1'b1;
        dv = {8'($urandom()), $urandom()};
        set_data(dv);
        rd(`LCC_OFS_QREG, {22'h0, d3of(dv)}, 32'h3ff);
        cell_sload <= 1'b0;
        rd(`LCC_OFS_QREG, 32'h0, 32'h3ff);
        $display("test register done");
        repeat (3) @(posedge clk);
        summarize();
    end
endmodule : lcc_cluster_tb_top
